// File: hdl/video_mixer_params.svh
// Constants shared by both ends of the two-input video mixer.
`ifndef VIDEO_MIXER_PARAMS_SVH
`define VIDEO_MIXER_PARAMS_SVH
`define VM_DATA_W      12
`define VM_FACTOR_W    12
`define VM_DWORD_W     15
`define VM_DFIELD_W    3
`define VM_MAX_DELAY   7
`define VM_DLY_A_LSB   0
`define VM_DLY_B_LSB   3
`define VM_DLY_M_LSB   6
`define VM_DLY_F_LSB   9
`define VM_DLY_R_LSB   12
`define VM_OUT_W       27
`define VM_FULL_SCALE  12'hFFF
`define VM_ZERO        12'h000
`endif

// File: hdl/video_mixer_pkg.sv
// Types shared by both ends of the two-input video mixer.
`default_nettype none
`include "video_mixer_params.svh"
package video_mixer_pkg;
    // Controller sequencing modes.
    typedef enum logic [2:0] {MODE_IDLE, MODE_SWITCH, MODE_FADE, MODE_BLACK, MODE_DISSOLVE} mode_t;
    // Controller state.
    typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_DOWN, ST_HOLD, ST_UP} ctrl_state_t;
    // Round modes: none, to 8, 10 or 12 output bits.
    typedef logic [1:0] round_t;
endpackage
`default_nettype wire

// File: hdl/video_mixer_if.sv
// Pin-level link between the mixer and its controller.
`default_nettype none
`include "video_mixer_params.svh"
interface video_mixer_if;
    logic [`VM_DATA_W-1:0]   first_video_input;       // First video input word.
    logic [`VM_DATA_W-1:0]   second_video_input;      // Second video input word.
    logic [`VM_FACTOR_W-1:0] mix_factor;              // Mix factor, fraction of full scale.
    logic                    factor_load_enable;      // Factor capture enable.
    logic                    signed_format_select;    // High for two's complement data.
    logic [1:0]              round_factor;            // Output round selection.
    logic                    delay_word_serial_in;    // Delay word serial data.
    logic                    delay_word_shift_strobe; // One pulse per delay word bit.
    // The mixer end receives every pin.
    modport mixer (input first_video_input, second_video_input, mix_factor, factor_load_enable,
                   signed_format_select, round_factor, delay_word_serial_in, delay_word_shift_strobe);
    // The controller end drives every pin.
    modport ctrl (output first_video_input, second_video_input, mix_factor, factor_load_enable,
                  signed_format_select, round_factor, delay_word_serial_in, delay_word_shift_strobe);
endinterface
`default_nettype wire

// File: hdl/video_mixer_core.sv
// Mixer end: delay lines, factor capture, weighted sum, round, output buffer.
`default_nettype none
`include "video_mixer_params.svh"
module video_mixer_core (
    input  wire logic                 CLK,        // System clock.
    input  wire logic                 SRST,       // Synchronous reset, active high.
    video_mixer_if.mixer              LINK,       // Pins from the controller.
    output logic [`VM_OUT_W-1:0]      DOUT,       // Mixed output word, registered.
    output logic                      DOUT_VALID, // Output word is valid.
    input  wire logic                 DOUT_READY  // Receiver accepts the word.
);
    import video_mixer_pkg::*;

    localparam int DW = `VM_DATA_W;
    localparam int FW = `VM_FACTOR_W;
    localparam int GW = 2 * DW + 2 + 1;             // Packed group width: A, B, factor is apart.

    // Delay word shift register and the word in effect.
    logic [`VM_DWORD_W-1:0] shift_word, next_shift_word;
    logic [3:0]             bit_count, next_bit_count;
    logic [`VM_DWORD_W-1:0] dly_word, next_dly_word;

    // Taps of each delay line, index zero is the undelayed pin.
    logic [DW-1:0] a_tap [0:`VM_MAX_DELAY];
    logic [DW-1:0] b_tap [0:`VM_MAX_DELAY];
    logic [FW-1:0] m_tap [0:`VM_MAX_DELAY];
    logic          e_tap [0:`VM_MAX_DELAY];
    logic          f_tap [0:`VM_MAX_DELAY];
    logic [1:0]    r_tap [0:`VM_MAX_DELAY];
    logic [DW-1:0] next_a_tap [1:`VM_MAX_DELAY];
    logic [DW-1:0] next_b_tap [1:`VM_MAX_DELAY];
    logic [FW-1:0] next_m_tap [1:`VM_MAX_DELAY];
    logic          next_e_tap [1:`VM_MAX_DELAY];
    logic          next_f_tap [1:`VM_MAX_DELAY];
    logic [1:0]    next_r_tap [1:`VM_MAX_DELAY];

    // Selected, delayed operands.
    logic [DW-1:0] a_sel, b_sel;
    logic [FW-1:0] m_sel;
    logic          e_sel, f_sel;
    logic [1:0]    r_sel;

    // Held mix factor.
    logic [FW-1:0] factor, next_factor;

    // Result and two-entry output buffer.
    logic signed [`VM_OUT_W-1:0] mix_result;
    logic [`VM_OUT_W-1:0] buf_data [0:1];
    logic [`VM_OUT_W-1:0] next_buf_data [0:1];
    logic [1:0]           buf_count, next_buf_count;

    assign a_tap[0] = LINK.first_video_input;
    assign b_tap[0] = LINK.second_video_input;
    assign m_tap[0] = LINK.mix_factor;
    assign e_tap[0] = LINK.factor_load_enable;
    assign f_tap[0] = LINK.signed_format_select;
    assign r_tap[0] = LINK.round_factor;

    // Serial delay word loader: one bit per strobe, LSB first; new word applies after fifteen bits.
    always_comb begin
        next_shift_word = shift_word;
        next_bit_count  = bit_count;
        next_dly_word   = dly_word;
        if (LINK.delay_word_shift_strobe) begin
            next_shift_word = {LINK.delay_word_serial_in, shift_word[`VM_DWORD_W-1:1]};
            if (bit_count == 4'(`VM_DWORD_W - 1)) begin
                next_dly_word  = {LINK.delay_word_serial_in, shift_word[`VM_DWORD_W-1:1]};
                next_bit_count = 4'h0;
            end else begin
                next_bit_count = bit_count + 4'h1;
            end
        end
    end

    // Registers of the delay word loader.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            shift_word <= '0;
            bit_count  <= 4'h0;
            dly_word   <= '0;
        end else begin
            shift_word <= next_shift_word;
            bit_count  <= next_bit_count;
            dly_word   <= next_dly_word;
        end
    end

    // Delay line shifts; every stage moves every clock.
    always_comb begin
        for (int i = 1; i <= `VM_MAX_DELAY; i++) begin
            next_a_tap[i] = a_tap[i-1];
            next_b_tap[i] = b_tap[i-1];
            next_m_tap[i] = m_tap[i-1];
            next_e_tap[i] = e_tap[i-1];
            next_f_tap[i] = f_tap[i-1];
            next_r_tap[i] = r_tap[i-1];
        end
    end

    // Delay line registers.
    always_ff @(posedge CLK) begin
        for (int i = 1; i <= `VM_MAX_DELAY; i++) begin
            if (SRST) begin
                a_tap[i] <= '0;
                b_tap[i] <= '0;
                m_tap[i] <= '0;
                e_tap[i] <= 1'b0;
                f_tap[i] <= 1'b0;
                r_tap[i] <= 2'h0;
            end else begin
                a_tap[i] <= next_a_tap[i];
                b_tap[i] <= next_b_tap[i];
                m_tap[i] <= next_m_tap[i];
                e_tap[i] <= next_e_tap[i];
                f_tap[i] <= next_f_tap[i];
                r_tap[i] <= next_r_tap[i];
            end
        end
    end

    // Tap selection by the three-bit fields; the enable travels with the factor.
    always_comb begin
        a_sel = a_tap[dly_word[`VM_DLY_A_LSB +: `VM_DFIELD_W]];
        b_sel = b_tap[dly_word[`VM_DLY_B_LSB +: `VM_DFIELD_W]];
        m_sel = m_tap[dly_word[`VM_DLY_M_LSB +: `VM_DFIELD_W]];
        e_sel = e_tap[dly_word[`VM_DLY_M_LSB +: `VM_DFIELD_W]];
        f_sel = f_tap[dly_word[`VM_DLY_F_LSB +: `VM_DFIELD_W]];
        r_sel = r_tap[dly_word[`VM_DLY_R_LSB +: `VM_DFIELD_W]];
    end

    // Factor capture while the enable is high, otherwise the old factor stays.
    always_comb begin
        next_factor = e_sel ? m_sel : factor;
    end

    // Factor register.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            factor <= '0;
        end else begin
            factor <= next_factor;
        end
    end

    // Weighted sum 2*(A*M + B*(1-M)) scaled by 2^FW; then optional rounding.
    always_comb begin
        logic signed [DW+1:0]     a_ext;
        logic signed [DW+1:0]     b_ext;
        logic signed [FW+1:0]     m_ext;
        logic signed [FW+1:0]     mc_ext;
        logic signed [`VM_OUT_W-1:0] sum;
        logic signed [`VM_OUT_W-1:0] half;
        int                       keep;
        half   = '0;
        keep   = 0;
        a_ext  = f_sel ? {{2{a_sel[DW-1]}}, a_sel} : {2'b00, a_sel};
        b_ext  = f_sel ? {{2{b_sel[DW-1]}}, b_sel} : {2'b00, b_sel};
        m_ext  = {2'b00, factor};
        mc_ext = (FW+2)'(1 << FW) - m_ext;
        // Operands are widened first so that the products keep every bit.
        sum    = (`VM_OUT_W'(a_ext) * `VM_OUT_W'(m_ext) + `VM_OUT_W'(b_ext) * `VM_OUT_W'(mc_ext)) <<< 1;
        // Round to 8, 10 or 12 integer bits; zero passes full precision.
        case (r_sel)
            2'h1:    keep = 8;
            2'h2:    keep = 10;
            2'h3:    keep = DW;
            default: keep = 0;
        endcase
        if (keep == 0) begin
            mix_result = sum;
        end else begin
            half       = `VM_OUT_W'(1) <<< (FW + DW - keep);
            mix_result = (sum + half) & ~((half <<< 1) - `VM_OUT_W'(1));
        end
    end

    // Two-entry output buffer; stall by the receiver holds both words.
    always_comb begin
        logic push;
        logic pop;
        push = 1'b1;
        pop  = DOUT_READY && (buf_count != 2'h0);
        next_buf_data[0] = buf_data[0];
        next_buf_data[1] = buf_data[1];
        next_buf_count   = buf_count;
        if (buf_count == 2'h2 && !pop) begin
            push = 1'b0;                      // Buffer full: the newest sample is dropped.
        end
        if (pop) begin
            next_buf_data[0] = buf_data[1];
        end
        if (push) begin
            if (next_buf_count - (pop ? 2'h1 : 2'h0) == 2'h0) begin
                next_buf_data[0] = mix_result;
            end else begin
                next_buf_data[1] = mix_result;
            end
        end
        next_buf_count = buf_count + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    end

    // Output buffer registers.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            buf_data[0] <= '0;
            buf_data[1] <= '0;
            buf_count   <= 2'h0;
        end else begin
            buf_data[0] <= next_buf_data[0];
            buf_data[1] <= next_buf_data[1];
            buf_count   <= next_buf_count;
        end
    end

    assign DOUT       = buf_data[0];
    assign DOUT_VALID = (buf_count != 2'h0);
endmodule
`default_nettype wire

// File: hdl/video_mixer_ctrl.sv
// Controller end: delay word loader and fade, switch, fade-to-black and dissolve sequencing.
`default_nettype none
`include "video_mixer_params.svh"
module video_mixer_ctrl #(
    parameter int STEP_CLKS = 4        // Clocks each factor step is held (one frame in use).
) (
    input  wire logic                    CLK,         // System clock.
    input  wire logic                    SRST,        // Synchronous reset, active high.
    video_mixer_if.ctrl                  LINK,        // Pins to the mixer.
    input  wire logic                    START,       // Pulse: begin the selected sequence.
    input  wire video_mixer_pkg::mode_t  MODE,        // Sequence to run.
    input  wire logic [`VM_DWORD_W-1:0]  DELAY_WORD,  // Delay word to send before the sequence.
    input  wire logic [`VM_FACTOR_W-1:0] STEP,        // Factor step size.
    input  wire logic [15:0]             HOLD_CLKS,   // Black interval in clocks.
    input  wire logic [`VM_DATA_W-1:0]   IMAGE1,      // First image source.
    input  wire logic [`VM_DATA_W-1:0]   IMAGE2,      // Second image source.
    input  wire logic                    PIXEL_KEY,   // Per-pixel factor from a logic unit.
    input  wire logic                    FORMAT,      // Two's complement data when high.
    input  wire logic [1:0]              ROUND,       // Round selection for the last stage.
    output logic                         BUSY         // A sequence is running.
);
    import video_mixer_pkg::*;

    ctrl_state_t state, next_state;       // Sequencer state.
    mode_t       mode, next_mode;         // Latched mode.
    logic [`VM_DWORD_W-1:0] word, next_word;      // Delay word being shifted out.
    logic [3:0]  nbits, next_nbits;       // Bits sent.
    logic [15:0] cnt, next_cnt;           // Step and hold timer.
    logic [`VM_FACTOR_W-1:0] m, next_m;   // Factor driven.
    logic        en, next_en;             // Load enable driven.
    logic        swapped, next_swapped;   // First input now carries the second image.

    // Sequencer next-state logic.
    always_comb begin
        next_state = state; next_mode = mode; next_word = word; next_nbits = nbits;
        next_cnt = cnt; next_m = m; next_en = en; next_swapped = swapped;
        case (state)
            ST_IDLE: begin
                if (START) begin
                    next_mode = MODE; next_word = DELAY_WORD; next_nbits = 4'h0;
                    next_state = ST_LOAD; next_swapped = 1'b0; next_m = `VM_FULL_SCALE;
                end
            end
            ST_LOAD: begin                                    // One strobe per bit, LSB first.
                next_word  = word >> 1;
                next_nbits = nbits + 4'h1;
                if (nbits == 4'(`VM_DWORD_W - 1)) begin
                    next_en = 1'b1; next_cnt = 16'h0;
                    next_state = (mode == MODE_SWITCH) ? ST_HOLD : ST_DOWN;
                    if (mode == MODE_IDLE) begin next_state = ST_IDLE; next_en = 1'b0; end
                end
            end
            ST_DOWN: begin                                    // Staircase: step only when the timer ends.
                next_cnt = cnt + 16'h1;
                if (cnt == 16'(STEP_CLKS - 1)) begin
                    next_cnt = 16'h0;
                    // Zero must be captured with the enable high before the enable drops.
                    if (m == `VM_ZERO) begin
                        if (mode == MODE_FADE) begin next_en = 1'b0; next_state = ST_IDLE; end
                        else next_state = ST_HOLD;
                    end else begin
                        next_m = (m > STEP) ? m - STEP : `VM_ZERO;
                    end
                end
            end
            ST_HOLD: begin
                next_cnt = cnt + 16'h1;
                if (mode == MODE_SWITCH) begin
                    next_m = PIXEL_KEY ? `VM_FULL_SCALE : `VM_ZERO;
                    if (!PIXEL_KEY && cnt >= HOLD_CLKS) begin next_en = 1'b0; next_state = ST_IDLE; end
                end else if (cnt >= HOLD_CLKS) begin
                    next_swapped = 1'b1; next_cnt = 16'h0; next_state = ST_UP;
                end
            end
            ST_UP: begin
                next_cnt = cnt + 16'h1;
                if (cnt == 16'(STEP_CLKS - 1)) begin
                    next_cnt = 16'h0;
                    // Full scale stands one step with the enable high before the enable drops.
                    if (m == `VM_FULL_SCALE) begin next_en = 1'b0; next_state = ST_IDLE; end
                    else next_m = (`VM_FULL_SCALE - m > STEP) ? m + STEP : `VM_FULL_SCALE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state <= ST_IDLE; mode <= MODE_IDLE; word <= '0; nbits <= 4'h0;
            cnt <= 16'h0; m <= `VM_FULL_SCALE; en <= 1'b0; swapped <= 1'b0;
        end else begin
            state <= next_state; mode <= next_mode; word <= next_word; nbits <= next_nbits;
            cnt <= next_cnt; m <= next_m; en <= next_en; swapped <= next_swapped;
        end
    end

    // Pin drive; dissolve uses the logic-unit key, inverted after the swap.
    always_comb begin
        LINK.delay_word_shift_strobe = (state == ST_LOAD);
        LINK.delay_word_serial_in    = (state == ST_LOAD) ? word[0] : 1'b0;
        LINK.first_video_input       = swapped ? IMAGE2 : IMAGE1;
        LINK.second_video_input      = (mode == MODE_FADE || mode == MODE_SWITCH) ? IMAGE2 : `VM_ZERO;
        LINK.mix_factor              = m;
        if (mode == MODE_DISSOLVE && state != ST_IDLE && state != ST_LOAD) begin
            LINK.mix_factor = (PIXEL_KEY ^ swapped) ? `VM_ZERO : `VM_FULL_SCALE;
        end
        LINK.factor_load_enable      = en;
        LINK.signed_format_select    = FORMAT;
        LINK.round_factor            = ROUND;
        BUSY                         = (state != ST_IDLE);
    end
endmodule
`default_nettype wire

// File: dv/video_mixer_checker.sv
// Concurrent checks on the mixer link pins and the mixer output buffer.
`default_nettype none
`include "video_mixer_params.svh"
module video_mixer_checker #(
    parameter int STEP_CLKS = 4  // Clocks each fade step must stand.
) (
    input wire logic                    CLK,
    input wire logic                    SRST,
    input wire logic [`VM_FACTOR_W-1:0] mix_factor,
    input wire logic                    factor_load_enable,
    input wire logic                    delay_word_serial_in,
    input wire logic                    delay_word_shift_strobe,
    input wire logic [`VM_OUT_W-1:0]    DOUT,
    input wire logic                    DOUT_VALID,
    input wire logic                    DOUT_READY,
    input wire logic                    BUSY,
    input wire video_mixer_pkg::mode_t  MODE,
    input wire logic [`VM_DWORD_W-1:0]  DELAY_WORD
);
    import video_mixer_pkg::*;
    logic [4:0]              run_len; // Strobe-high cycles in the current run.
    logic [`VM_DWORD_W-1:0]  rebuilt; // Delay word rebuilt from the serial pin.
    logic [15:0]             stand;   // Samples the present factor has stood.
    logic [`VM_FACTOR_W-1:0] prev_m;  // Factor seen at the previous sample.
    // Tracks strobe runs, the shifted word and how long each factor value stands.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            run_len <= 5'h00;
            stand <= 16'h0000;
        end else begin
            run_len <= delay_word_shift_strobe ? run_len + 5'h01 : 5'h00;
            stand <= (mix_factor != prev_m) ? 16'h0001 : stand + 16'h0001;
        end
        prev_m <= mix_factor;
        if (delay_word_shift_strobe) begin
            rebuilt <= {delay_word_serial_in, rebuilt[`VM_DWORD_W-1:1]};
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    property p_stall_hold;
        DOUT_VALID && !DOUT_READY |=> DOUT_VALID && $stable(DOUT);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("Output word lost while stalled.");
    property p_reset_empty;
        $fell(SRST) |-> !DOUT_VALID && DOUT == 27'h0000000;
    endproperty
    a_reset_empty: assert property (p_reset_empty) else $error("Output not cleared by reset.");
    property p_strobe_count;
        $fell(delay_word_shift_strobe) |-> run_len == 5'h0F;
    endproperty
    a_strobe_count: assert property (p_strobe_count) else $error("Strobe run is not fifteen.");
    property p_word_order;
        $fell(delay_word_shift_strobe) |-> rebuilt == DELAY_WORD;
    endproperty
    a_word_order: assert property (p_word_order) else $error("Delay word bit order wrong.");
    property p_binary_factor;
        BUSY && factor_load_enable && (MODE == MODE_SWITCH || MODE == MODE_DISSOLVE)
            |-> mix_factor == `VM_ZERO || mix_factor == `VM_FULL_SCALE;
    endproperty
    a_binary_factor: assert property (p_binary_factor) else $error("Factor not zero or full.");
    property p_fade_stairs;
        BUSY && MODE == MODE_FADE && factor_load_enable && $past(factor_load_enable)
            && $changed(mix_factor) |-> stand >= STEP_CLKS;
    endproperty
    a_fade_stairs: assert property (p_fade_stairs) else $error("Fade step held too briefly.");
    property p_fade_down;
        BUSY && MODE == MODE_FADE && factor_load_enable && $past(factor_load_enable)
            |-> mix_factor <= $past(mix_factor);
    endproperty
    a_fade_down: assert property (p_fade_down) else $error("Fade factor rose.");
    property p_fade_end;
        MODE == MODE_FADE && $fell(factor_load_enable) |-> $past(mix_factor) == `VM_ZERO;
    endproperty
    a_fade_end: assert property (p_fade_end) else $error("Fade ended above zero.");
    property p_black_end;
        MODE == MODE_BLACK && $fell(factor_load_enable) |-> $past(mix_factor) == `VM_FULL_SCALE;
    endproperty
    a_black_end: assert property (p_black_end) else $error("Fade-to-black ended below full.");
endmodule
`default_nettype wire

// File: dv/tb_two_input_video_mixer.sv
// Bench: controller drives the mixer through the link, a mirror predicts every output word.
`default_nettype none
`include "video_mixer_params.svh"
module tb_two_input_video_mixer;
    timeunit 1ns;
    timeprecision 1ns;
    import video_mixer_pkg::*;
    logic                    clk, srst, start, pixel_key, format, busy;
    mode_t                   mode;
    logic [`VM_DWORD_W-1:0]  delay_word, sh, word;
    logic [`VM_FACTOR_W-1:0] step, fac;
    logic [15:0]             hold_clks;
    logic [`VM_DATA_W-1:0]   image1, image2;
    logic [`VM_OUT_W-1:0]    dout;
    logic                    dout_valid, dout_ready;
    logic [1:0]              rnd;      // Round selection driven to the controller.
    logic [7:0][39:0]        hist;     // Newest pin sample first, seven older behind it.
    logic [`VM_OUT_W-1:0]    exp_q[$]; // Expected words, oldest first.
    int                      fails, n_checks, nbits;
    video_mixer_if link ();
    video_mixer_core video_mixer_core_i (.CLK(clk), .SRST(srst), .LINK(link.mixer), .DOUT(dout),
        .DOUT_VALID(dout_valid), .DOUT_READY(dout_ready));
    video_mixer_ctrl #(.STEP_CLKS(3)) video_mixer_ctrl_i (.CLK(clk), .SRST(srst), .LINK(link.ctrl),
        .START(start), .MODE(mode), .DELAY_WORD(delay_word), .STEP(step), .HOLD_CLKS(hold_clks),
        .IMAGE1(image1), .IMAGE2(image2), .PIXEL_KEY(pixel_key), .FORMAT(format), .ROUND(rnd), .BUSY(busy));
    video_mixer_checker #(.STEP_CLKS(3)) video_mixer_checker_i (.CLK(clk), .SRST(srst),
        .mix_factor(link.mix_factor), .factor_load_enable(link.factor_load_enable),
        .delay_word_serial_in(link.delay_word_serial_in), .delay_word_shift_strobe(link.delay_word_shift_strobe),
        .DOUT(dout), .DOUT_VALID(dout_valid), .DOUT_READY(dout_ready), .BUSY(busy), .MODE(mode),
        .DELAY_WORD(delay_word));
    // Free-running clock, 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Counts a comparison and reports a mismatch.
    task automatic check(input string what, input logic [`VM_OUT_W-1:0] seen, input logic [`VM_OUT_W-1:0] want);
        n_checks++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic conclude();
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Starts one sequence and waits, bounded, for the controller to go idle.
    task automatic run(input mode_t m, input logic [`VM_DWORD_W-1:0] w);
        mode <= m;
        delay_word <= w;
        step <= 12'h200;
        hold_clks <= 16'h0006;
        format <= 1'($urandom);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int n = 0; n <= 4000; n++) begin
            @(posedge clk);
            if (busy === 1'b0) begin
                break;
            end
            if (n == 4000) begin
                fails++;
                conclude();
            end
        end
    endtask
    // Video, key and receiver stalls change at random every clock.
    always @(posedge clk) begin
        image1 <= 12'($urandom);
        rnd <= 2'($urandom);
        image2 <= 12'($urandom);
        pixel_key <= 1'($urandom);
        dout_ready <= 1'($urandom);
    end
    // Mirror of the mixer: delay word, delay lines, factor register and two-entry buffer.
    always @(posedge clk) begin : mirror
        logic   fmt;
        longint a, b, r;
        int     k;
        hist = {hist[6:0], link.round_factor, link.signed_format_select, link.factor_load_enable, link.mix_factor,
                link.second_video_input, link.first_video_input};
        if (srst) begin
            word = 15'h0000;
            nbits = 0;
            fac = 12'h000;
            exp_q.delete();
        end else begin
            fmt = hist[word[11:9]][37];
            a = fmt ? longint'($signed(hist[word[2:0]][11:0])) : longint'(hist[word[2:0]][11:0]);
            b = fmt ? longint'($signed(hist[word[5:3]][23:12])) : longint'(hist[word[5:3]][23:12]);
            r = 2 * (a * longint'(fac) + b * (4096 - longint'(fac)));
            // Round modes keep 8, 10 or 12 integer bits, adding half of the kept LSB first.
            if (hist[word[14:12]][39:38] != 2'h0) begin
                k = (hist[word[14:12]][39:38] == 2'h1) ? 8 : (hist[word[14:12]][39:38] == 2'h2) ? 10 : 12;
                r = (r + (longint'(1) <<< (24 - k))) & ~((longint'(2) <<< (24 - k)) - 1);
            end
            // The factor register used above is the one captured at the previous edge.
            if (hist[word[8:6]][36]) begin
                fac = hist[word[8:6]][35:24];
            end
            if (link.delay_word_shift_strobe) begin
                sh = {link.delay_word_serial_in, sh[14:1]};
                nbits++;
                if (nbits == 15) begin
                    word = sh;
                    nbits = 0;
                end
            end
            #1;
            // A full buffer with no taker drops the new word; a taken word was already popped.
            if (exp_q.size() != 2) begin
                exp_q.push_back(r[`VM_OUT_W-1:0]);
            end
        end
    end
    // Takes the oldest note whenever the mixer hands a word over.
    always @(posedge clk) begin
        if (srst === 1'b0) begin
            check("dout_valid", `VM_OUT_W'(dout_valid), `VM_OUT_W'(exp_q.size() != 0));
            if (dout_valid === 1'b1 && dout_ready === 1'b1 && exp_q.size() != 0) begin
                check("dout", dout, exp_q.pop_front());
            end
        end
    end
    // Reset, then every mode with no, random and maximum delays.
    initial begin
        srst = 1'b1;
        start = 1'b0;
        mode = MODE_IDLE;
        delay_word = 15'h0000;
        step = 12'h200;
        hold_clks = 16'h0006;
        image1 = 12'h000;
        image2 = 12'h000;
        pixel_key = 1'b0;
        format = 1'b0;
        rnd = 2'h0;
        dout_ready = 1'b0;
        fails = 0;
        n_checks = 0;
        void'($urandom(32'hF309));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            run(mode_t'(i % 5), (i < 5) ? 15'h0000 : (i < 10) ? 15'($urandom) : 15'h7FFF);
        end
        repeat (20) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
